/* File: sim/pfu_assertions.sv */
/* Port checker of the program flow unit.
   Assumes it is bound to pfu_top and sees only its ports. */
`timescale 1ns/1ps
module pfu_assertions (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic [pfu_pkg::AVS_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_WRITE,
  input wire logic [pfu_pkg::AVS_DATA_W-1:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic I_ADVANCE,
  input wire logic I_JUMP,
  input wire logic I_CALL,
  input wire logic I_INT_BRANCH,
  input wire logic I_RETURN,
  input wire logic [pfu_pkg::TARGET_W-1:0] I_TARGET,
  input wire logic [pfu_pkg::PC_W-1:0] O_PC,
  input wire logic [pfu_pkg::DATA_ADDR_W-1:0] O_MEM_ADDR,
  input wire logic O_MEM_RD,
  input wire logic O_MEM_WR
);
  logic quiet;
  logic wr_ack;
  logic ret_only;
  assign quiet = !(I_JUMP || I_CALL || I_INT_BRANCH || I_RETURN);
  assign wr_ack = I_AVS_WRITE && !O_AVS_WAITREQUEST;
  assign ret_only = I_RETURN && !(I_JUMP || I_CALL || I_INT_BRANCH);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  ////////////////////////////////////////
  a_pc_reset: assert property (disable iff (1'b0) I_RESET |=> O_PC == 13'h0000)
    else $error("counter not cleared");
  a_pc_advance: assert property (I_ADVANCE && quiet && !wr_ack |=> O_PC == $past(O_PC) + 13'h1)
    else $error("advance wrong");
  a_pc_hold: assert property (!I_ADVANCE && quiet && !wr_ack |=> $stable(O_PC))
    else $error("counter moved");
  a_low_write: assert property (wr_ack && quiet && I_AVS_BYTEENABLE[0]
    && I_AVS_ADDRESS == pfu_pkg::OFS_PC_LOW |=> O_PC[7:0] == $past(I_AVS_WRITEDATA[7:0]))
    else $error("low byte write lost");
  a_jump_target: assert property ((I_JUMP || I_CALL) && !I_INT_BRANCH
    |=> O_PC[10:0] == $past(I_TARGET))
    else $error("jump target wrong");
  a_int_vector: assert property (I_INT_BRANCH |=> O_PC == pfu_pkg::INT_VECTOR)
    else $error("interrupt entry wrong");
  a_call_return: assert property (I_CALL && !I_INT_BRANCH ##1 ret_only
    |=> O_PC == $past(O_PC, 2) + 13'h1)
    else $error("return address wrong");
  a_read_answer: assert property (O_MEM_RD |=> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("indirect read late");
  a_self_read: assert property (O_MEM_RD |-> O_MEM_ADDR[6:0] != 7'h00)
    else $error("self read reached memory");
  a_self_write: assert property (O_MEM_WR |-> O_MEM_ADDR[6:0] != 7'h00 && wr_ack)
    else $error("self write reached memory");
  c_call_ret: cover property (I_CALL ##1 ret_only);
  c_int: cover property (I_INT_BRANCH);
  c_mem_rd: cover property (O_MEM_RD);
endmodule : pfu_assertions

bind pfu_top pfu_assertions chk_u (.I_CLK, .I_RESET, .I_AVS_ADDRESS, .I_AVS_WRITE,
  .I_AVS_WRITEDATA, .I_AVS_BYTEENABLE, .O_AVS_WAITREQUEST, .I_ADVANCE, .I_JUMP, .I_CALL,
  .I_INT_BRANCH, .I_RETURN, .I_TARGET, .O_PC, .O_MEM_ADDR, .O_MEM_RD, .O_MEM_WR);

/* File: sim/pfu_mem_model.sv */
/* Behavioural data memory behind the indirect port.
   Assumes one-cycle strobes on the core clock. */
`timescale 1ns/1ps
module pfu_mem_model (
  input wire logic i_clk,
  input wire logic [8:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [512];
  logic [7:0] last;
  logic [8:0] a_q;
  logic rd_q;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    last = 8'h00;
    rd_q = 1'b0;
    a_q = 9'h000;
  end
  always @(posedge i_clk) begin
    rd_q <= i_rd;
    a_q <= i_addr;
    if (i_wr) mem[i_addr] <= i_wdata;
    if (rd_q) last <= mem[a_q];
  end
  // Outside the answer cycle the inverse shows, so stale data cannot pass.
  assign o_rdata = rd_q ? mem[a_q] : ~last;
endmodule : pfu_mem_model

/* File: sim/pfu_top_tb.sv */
/* Self-checking bench of the program flow unit.
   Assumes the memory model and the bound port checker. */
`timescale 1ns/1ps
module pfu_top_tb;
  logic clk, rst, rd, wr, bank, wq, mrd, mwr;
  logic [4:0] adr, ctl, lat;
  logic [31:0] wd, rdat, q;
  logic [10:0] tgt;
  logic [12:0] pc, pc_m;
  logic [12:0] st [8];
  logic [8:0] maddr;
  logic [7:0] mwd, mrdat;
  logic [2:0] sp;
  logic [3:0] be;
  int fail_count = 0;
  int cmp_count = 0;
  pfu_top dut_u (.I_CLK(clk), .I_RESET(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq), .I_ADVANCE(ctl[0]), .I_JUMP(ctl[2]),
    .I_CALL(ctl[3]), .I_INT_BRANCH(ctl[4]), .I_RETURN(ctl[1]), .I_TARGET(tgt),
    .I_HIGH_BANK_SELECT(bank), .O_PC(pc), .O_MEM_ADDR(maddr), .O_MEM_RD(mrd),
    .O_MEM_WR(mwr), .O_MEM_WDATA(mwd), .I_MEM_RDATA(mrdat));
  pfu_mem_model mem_u (.i_clk(clk), .i_addr(maddr), .i_rd(mrd), .i_wr(mwr),
    .i_wdata(mwd), .o_rdata(mrdat));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : check
  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic avs(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (w && be[0] && a == pfu_pkg::OFS_HOLDING_LATCH) lat = d[4:0];
    if (w && be[0] && a == pfu_pkg::OFS_PC_LOW) pc_m = {lat, d};
  endtask : avs
  task automatic op(input logic [4:0] c, input logic [10:0] t);
    @(posedge clk);
    ctl <= c;
    tgt <= t;
    @(posedge clk);
    ctl <= 5'h00;
    if (c[4] || c[3]) begin
      st[sp] = pc_m + 13'h1;
      sp++;
    end
    if (c[4]) pc_m = pfu_pkg::INT_VECTOR;
    else if (c[3] || c[2]) pc_m = {lat[4:3], t};
    else if (c[1]) begin
      sp--;
      pc_m = st[sp];
    end else if (c[0]) pc_m++;
    @(negedge clk);
    check(32'(pc), 32'(pc_m));
  endtask : op
  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    pc_m = 13'h0;
    sp = 3'h0;
    lat = 5'h0;
    foreach (st[i]) st[i] = 13'h0;
    @(negedge clk);
    check(32'(pc), 32'h0);
  endtask : do_reset
  ////////////////////////////////////////
  task automatic t_pc_low();
    avs(1'b1, pfu_pkg::OFS_HOLDING_LATCH, 8'h15);
    avs(1'b1, pfu_pkg::OFS_PC_LOW, 8'ha7);
    @(negedge clk);
    check(32'(pc), 32'h15a7);
    avs(1'b0, pfu_pkg::OFS_PC_LOW, 8'h00);
    check(q, 32'ha7);
    op(5'h04, 11'h123);
    check(32'(pc), 32'h1123);
    avs(1'b0, 5'h14, 8'h00);
    check(q, 32'h0);
    be <= 4'h0;
    avs(1'b1, pfu_pkg::OFS_HOLDING_LATCH, 8'h0a);
    be <= 4'h1;
    avs(1'b0, pfu_pkg::OFS_HOLDING_LATCH, 8'h00);
    check(q, 32'h15);
  endtask : t_pc_low
  task automatic t_stack();
    do_reset();
    avs(1'b1, pfu_pkg::OFS_HOLDING_LATCH, 8'h1f);
    for (int i = 0; i < 9; i++) op((i == 4) ? 5'h10 : 5'h08, 11'(i * 16 + 3));
    op(5'h01, 11'h0);
    for (int i = 0; i < 10; i++) op(5'h02, 11'h0);
    @(posedge clk);
    ctl <= 5'h08;
    tgt <= 11'h2aa;
    @(posedge clk);
    ctl <= 5'h02;
    @(posedge clk);
    ctl <= 5'h00;
    @(negedge clk);
    check(32'(pc), 32'(pc_m + 13'h1));
    pc_m++;
    avs(1'b0, pfu_pkg::OFS_HOLDING_LATCH, 8'h00);
    check(q, 32'h1f);
    op(5'h08, 11'h055);
    op(5'h06, 11'h066);
    op(5'h02, 11'h000);
  endtask : t_stack
  task automatic t_indirect();
    @(posedge clk);
    bank <= 1'b1;
    mem_u.mem[9'h180] = 8'h3c;
    avs(1'b1, pfu_pkg::OFS_FILE_POINTER, 8'h45);
    avs(1'b0, pfu_pkg::OFS_INDIRECT_ADDR, 8'h00);
    check(q, 32'h145);
    avs(1'b1, pfu_pkg::OFS_INDIRECT_PORT, 8'h5a);
    avs(1'b0, pfu_pkg::OFS_INDIRECT_PORT, 8'h00);
    check(q, 32'h5a);
    check(32'(mem_u.mem[9'h145]), 32'h5a);
    avs(1'b1, pfu_pkg::OFS_FILE_POINTER, 8'h80);
    avs(1'b0, pfu_pkg::OFS_INDIRECT_ADDR, 8'h00);
    check(q, 32'h380);
    avs(1'b1, pfu_pkg::OFS_INDIRECT_PORT, 8'h77);
    avs(1'b0, pfu_pkg::OFS_INDIRECT_PORT, 8'h00);
    check(q, 32'h0);
    check(32'(mem_u.mem[9'h180]), 32'h3c);
  endtask : t_indirect
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wd = 32'h0;
    ctl = 5'h00;
    tgt = 11'h0;
    bank = 1'b0;
    be = 4'h1;
    do_reset();
    t_pc_low();
    t_stack();
    t_indirect();
    conclude();
  end
endmodule : pfu_top_tb

/* File: src/pfu_pkg.sv */
/*
  Shared constants and types of the program flow unit: widths, register byte
  offsets on the Avalon-MM slave, reset values, the interrupt entry address and
  the bus-handshake states.
  Assumes a single 100 MHz core clock and a synchronous active-high reset.
*/
package pfu_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int LATCH_W = 5;
  localparam int TARGET_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;
  localparam int DATA_ADDR_W = 9;
  localparam int BANK_OFS_W = 7;
  localparam int AVS_ADDR_W = 5;
  localparam int AVS_DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets, one aligned word each.
  localparam logic [AVS_ADDR_W-1:0] OFS_INDIRECT_PORT = 5'h00;
  localparam logic [AVS_ADDR_W-1:0] OFS_PC_LOW = 5'h04;
  localparam logic [AVS_ADDR_W-1:0] OFS_FILE_POINTER = 5'h08;
  localparam logic [AVS_ADDR_W-1:0] OFS_HOLDING_LATCH = 5'h0c;
  localparam logic [AVS_ADDR_W-1:0] OFS_INDIRECT_ADDR = 5'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset and fixed addresses.
  localparam logic [PC_W-1:0] RST_PC = 13'h0000;
  localparam logic [LATCH_W-1:0] RST_LATCH = 5'h00;
  localparam logic [LOW_W-1:0] RST_FILE_POINTER = 8'h00;
  localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
  localparam logic [BANK_OFS_W-1:0] PORT_BANK_OFS = 7'h00;
  localparam logic [LOW_W-1:0] PORT_SELF_READ = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Slave handshake states.
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_MEM_RD,
    BUS_MEM_CAP,
    BUS_ACK
  } pfu_bus_state_t;

endpackage : pfu_pkg

/* File: src/pfu_ret_stack.sv */
/*
  Eight-entry circular return-address stack with a hidden pointer.
  Assumes push and pop come from the sequencer on the same clock; push wins
  if both are raised together.
*/
`timescale 1ns/1ps
module pfu_ret_stack (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [pfu_pkg::PC_W-1:0] i_push_data,
  output logic [pfu_pkg::PC_W-1:0] o_top
);

  logic [pfu_pkg::PC_W-1:0] mem [pfu_pkg::STACK_DEPTH];
  logic [pfu_pkg::STACK_PTR_W-1:0] ptr;
  logic [pfu_pkg::STACK_PTR_W-1:0] prev_ptr;

  ////////////////////////////////////////////////////////////////////////////////
  assign prev_ptr = ptr - 3'h1;
  assign o_top = mem[prev_ptr];

  // R10 pointer wraps naturally.
  // R11 no overflow flag.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ptr <= '0;
    end else if (i_push) begin
      ptr <= ptr + 3'h1;
    end else if (i_pop) begin
      ptr <= prev_ptr;
    end
  end

  // R06 eight hidden entries.
  // Entries are cleared too so that the top never shows an unknown value.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < pfu_pkg::STACK_DEPTH; i++) begin
        mem[i] <= pfu_pkg::RST_PC;
      end
    end else if (i_push) begin
      mem[ptr] <= i_push_data;
    end
  end

endmodule : pfu_ret_stack

/* File: src/pfu_top.sv */
/*
  Program flow unit: program counter, upper-bits holding latch, return stack
  and indirect data addressing, with an Avalon-MM slave for software access.
  Assumes the sequencer drives its one-cycle controls on the same clock and
  that data memory returns read data on the cycle after its read strobe.
*/
//
// Summary of operation
// R01: Thirteen-bit counter, low byte read-write.
// R02: Upper bits only loaded from latch.
// R03: Every reset clears the whole counter.
// R04: Low-byte write loads latch bits upward.
// R05: Call or jump takes latch bits 4:3.
// R06: Eight by thirteen hidden stack.
// R07: Call or interrupt branch pushes counter.
// R08: Any return kind pops into counter.
// R09: Push and pop leave latch alone.
// R10: Stack wraps, ninth push overwrites first.
// R11: No overflow or underflow flags.
// R12: Indirect port accesses pointer-selected location.
// R13: Self-selected indirect read returns zero.
// R14: Self-selected indirect write stores nothing.
// R15: Nine-bit address from bank bit and pointer.
// R16: Computed jumps must mind 256-byte pages.
// R17: Bank bit is address bit 8.
// R18: Return address is next sequential instruction.
//
`timescale 1ns/1ps
module pfu_top (
  input wire logic I_CLK,
  input wire logic I_RESET,
  // Avalon-MM slave.
  input wire logic [pfu_pkg::AVS_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [pfu_pkg::AVS_DATA_W-1:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [pfu_pkg::AVS_DATA_W-1:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Instruction sequencer.
  input wire logic I_ADVANCE,
  input wire logic I_JUMP,
  input wire logic I_CALL,
  input wire logic I_INT_BRANCH,
  input wire logic I_RETURN,
  input wire logic [pfu_pkg::TARGET_W-1:0] I_TARGET,
  input wire logic I_HIGH_BANK_SELECT,
  output logic [pfu_pkg::PC_W-1:0] O_PC,
  // Data memory.
  output logic [pfu_pkg::DATA_ADDR_W-1:0] O_MEM_ADDR,
  output logic O_MEM_RD,
  output logic O_MEM_WR,
  output logic [pfu_pkg::LOW_W-1:0] O_MEM_WDATA,
  input wire logic [pfu_pkg::LOW_W-1:0] I_MEM_RDATA
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True when a data address lands on the indirect port of any bank.
  function automatic logic selects_port(input logic [pfu_pkg::DATA_ADDR_W-1:0] addr);
    selects_port = (addr[pfu_pkg::BANK_OFS_W-1:0] == pfu_pkg::PORT_BANK_OFS);
  endfunction : selects_port

  // R18 next sequential address.
  function automatic logic [pfu_pkg::PC_W-1:0] next_seq(input logic [pfu_pkg::PC_W-1:0] pc);
    next_seq = pc + 13'h0001;
  endfunction : next_seq

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  pfu_pkg::pfu_bus_state_t state;
  logic [pfu_pkg::PC_W-1:0] pc;
  logic [pfu_pkg::LATCH_W-1:0] pc_upper_holding_latch;
  logic [pfu_pkg::LOW_W-1:0] file_pointer_reg;
  logic [pfu_pkg::AVS_ADDR_W-1:0] req_addr;
  logic req_write;
  logic [pfu_pkg::LOW_W-1:0] req_data;
  logic [pfu_pkg::DATA_ADDR_W-1:0] indirect_addr;
  logic indirect_self;
  logic req_hit_port;
  logic ack_write;
  logic low_byte_we;
  logic seq_push;
  logic seq_pop;
  logic [pfu_pkg::PC_W-1:0] stack_top;
  logic [pfu_pkg::PC_W-1:0] next_pc;
  logic [pfu_pkg::AVS_DATA_W-1:0] next_readdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Indirect addressing.

  // R15 concatenate bank bit and pointer.
  // R17 bank bit on top.
  assign indirect_addr = {I_HIGH_BANK_SELECT, file_pointer_reg};
  assign indirect_self = selects_port(indirect_addr);
  assign req_hit_port = (I_AVS_ADDRESS == pfu_pkg::OFS_INDIRECT_PORT);

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM handshake.

  // The slave always holds waitrequest for at least one cycle so that read data
  // comes from a flip-flop and every write lands on the acknowledging edge.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      state <= pfu_pkg::BUS_IDLE;
    end else begin
      case (state)
        pfu_pkg::BUS_IDLE: begin
          if (I_AVS_READ && req_hit_port && !indirect_self) begin
            state <= pfu_pkg::BUS_MEM_RD;
          end else if (I_AVS_READ || I_AVS_WRITE) begin
            state <= pfu_pkg::BUS_ACK;
          end
        end
        pfu_pkg::BUS_MEM_RD: begin
          state <= pfu_pkg::BUS_MEM_CAP;
        end
        pfu_pkg::BUS_MEM_CAP: begin
          state <= pfu_pkg::BUS_ACK;
        end
        pfu_pkg::BUS_ACK: begin
          state <= pfu_pkg::BUS_IDLE;
        end
        default: begin
          state <= pfu_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign O_AVS_WAITREQUEST = (state != pfu_pkg::BUS_ACK);

  // The request is frozen when taken; the master holds it anyway.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      req_addr <= '0;
      req_write <= 1'b0;
      req_data <= '0;
    end else if (state == pfu_pkg::BUS_IDLE && (I_AVS_READ || I_AVS_WRITE)) begin
      req_addr <= I_AVS_ADDRESS;
      req_write <= I_AVS_WRITE && I_AVS_BYTEENABLE[0];
      req_data <= I_AVS_WRITEDATA[pfu_pkg::LOW_W-1:0];
    end
  end

  assign ack_write = (state == pfu_pkg::BUS_ACK) && req_write;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.

  always_comb begin
    next_readdata = '0;
    case (I_AVS_ADDRESS)
      pfu_pkg::OFS_INDIRECT_PORT: begin
        // R13 self-selection reads zero.
        next_readdata[pfu_pkg::LOW_W-1:0] = pfu_pkg::PORT_SELF_READ;
      end
      pfu_pkg::OFS_PC_LOW: begin
        // R01 low byte readable.
        next_readdata[pfu_pkg::LOW_W-1:0] = pc[pfu_pkg::LOW_W-1:0];
      end
      pfu_pkg::OFS_FILE_POINTER: begin
        next_readdata[pfu_pkg::LOW_W-1:0] = file_pointer_reg;
      end
      pfu_pkg::OFS_HOLDING_LATCH: begin
        next_readdata[pfu_pkg::LATCH_W-1:0] = pc_upper_holding_latch;
      end
      pfu_pkg::OFS_INDIRECT_ADDR: begin
        next_readdata[pfu_pkg::DATA_ADDR_W-1:0] = indirect_addr;
        next_readdata[pfu_pkg::DATA_ADDR_W] = indirect_self;
      end
      default: begin
        next_readdata = '0;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_AVS_READDATA <= '0;
    end else if (state == pfu_pkg::BUS_IDLE && I_AVS_READ) begin
      O_AVS_READDATA <= next_readdata;
    end else if (state == pfu_pkg::BUS_MEM_CAP) begin
      // R12 data comes from the selected location.
      O_AVS_READDATA <= {24'h000000, I_MEM_RDATA};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data memory port.

  // The address is caught once per request, so a pointer change later in the
  // same transfer cannot redirect it.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_MEM_ADDR <= '0;
      O_MEM_WDATA <= '0;
    end else if (state == pfu_pkg::BUS_IDLE && (I_AVS_READ || I_AVS_WRITE)) begin
      // R12 follow the file pointer.
      O_MEM_ADDR <= indirect_addr;
      O_MEM_WDATA <= I_AVS_WRITEDATA[pfu_pkg::LOW_W-1:0];
    end
  end

  assign O_MEM_RD = (state == pfu_pkg::BUS_MEM_RD);

  // R14 self-selected write dropped.
  assign O_MEM_WR = ack_write && (req_addr == pfu_pkg::OFS_INDIRECT_PORT)
                    && !selects_port(O_MEM_ADDR);

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers.

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      file_pointer_reg <= pfu_pkg::RST_FILE_POINTER;
    end else if (ack_write && req_addr == pfu_pkg::OFS_FILE_POINTER) begin
      file_pointer_reg <= req_data;
    end
  end

  // R09 only software writes change it.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      pc_upper_holding_latch <= pfu_pkg::RST_LATCH;
    end else if (ack_write && req_addr == pfu_pkg::OFS_HOLDING_LATCH) begin
      pc_upper_holding_latch <= req_data[pfu_pkg::LATCH_W-1:0];
    end
  end

  assign low_byte_we = ack_write && (req_addr == pfu_pkg::OFS_PC_LOW);

  ////////////////////////////////////////////////////////////////////////////////
  // Program counter.

  // R07 push on call or interrupt.
  assign seq_push = I_CALL || I_INT_BRANCH;
  // R08 pop on any return without a call or interrupt branch in the same cycle.
  // A jump in the same cycle wins, so the return is dropped whole, pop included.
  assign seq_pop = I_RETURN && !seq_push && !I_JUMP;

  // Sequencer branches outrank a software low-byte write in the same cycle;
  // the instruction stream owns the counter, software only nudges it.
  always_comb begin
    next_pc = pc;
    if (I_INT_BRANCH) begin
      next_pc = pfu_pkg::INT_VECTOR;
    end else if (I_CALL || I_JUMP) begin
      // R05 latch bits 4:3 on top.
      next_pc = {pc_upper_holding_latch[pfu_pkg::LATCH_W-1:pfu_pkg::LATCH_W-2], I_TARGET};
    end else if (I_RETURN) begin
      next_pc = stack_top;
    end else if (low_byte_we) begin
      // R04 latch fills the upper bits.
      // R16 a table crossing a page needs the latch updated first.
      next_pc = {pc_upper_holding_latch, req_data};
    end else if (I_ADVANCE) begin
      next_pc = next_seq(pc);
    end
  end

  // R02 upper bits never written from the bus directly.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      // R03 clear on reset.
      pc <= pfu_pkg::RST_PC;
    end else begin
      pc <= next_pc;
    end
  end

  assign O_PC = pc;

  ////////////////////////////////////////////////////////////////////////////////
  // Return stack.

  // R18 push the following address.
  pfu_ret_stack u_stack (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_push(seq_push),
    .i_pop(seq_pop),
    .i_push_data(next_seq(pc)),
    .o_top(stack_top)
  );

endmodule : pfu_top
